// ---- hw/ddr_burst2_sram_port_logic.v ----
// read/write port logic of a separate-i/o ddr burst-of-two sram
`default_nettype none
`include "sram_port_consts.vh"

module ddr_burst2_sram_port_logic #(
  parameter integer STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter integer CAL_PERIOD     = `CAL_PERIOD
) (
  input  wire               core_clk,
  input  wire               rst_n,
  input  wire               clk_en,
  input  wire               read_n,
  input  wire [`ADDR_W-1:0] read_addr,
  input  wire               write_n,
  input  wire [`ADDR_W-1:0] write_addr,
  input  wire [`DATA_W-1:0] write_data,
  input  wire [`LANES-1:0]  byte_lane_mask_n,
  input  wire               config_x18,
  input  wire               pu_cmp_raise,
  input  wire               pd_cmp_raise,
  output reg                k_phase,
  output reg  [`DATA_W-1:0] read_data,
  output reg                read_data_oe,
  output wire               calibrated,
  output wire [`CODE_W-1:0] pu_code,
  output wire [`CODE_W-1:0] pd_code
);

  // two beats per main clock: core_clk cycles alternate between the main
  // edge slot (k_phase low) and the inverted edge slot (k_phase high)

  reg               x18_s1_reg;
  reg               x18_s2_reg;
  reg               pu_s1_reg;
  reg               pu_s2_reg;
  reg               pd_s1_reg;
  reg               pd_s2_reg;

  reg               wr_pend_reg;
  reg [`DATA_W-1:0] wr_beat0_reg;
  reg [`LANES-1:0]  wr_mask0_reg;
  reg               rd_pend_reg;
  reg [`ADDR_W-1:0] rd_addr_reg;
  reg               beat1_pend_reg;
  reg [`DATA_W-1:0] beat1_reg;

  // one array per beat so a burst is one row; no reset, contents are data
  reg [`DATA_W-1:0] mem_beat0 [0:`WORDS-1];
  reg [`DATA_W-1:0] mem_beat1 [0:`WORDS-1];

  wire [`LANES-1:0]  mask1;
  wire               wr_go;
  wire               hit;
  wire [`DATA_W-1:0] new0;
  wire [`DATA_W-1:0] new1;
  wire [`DATA_W-1:0] rd0;
  wire [`DATA_W-1:0] rd1;
  wire [`DATA_W-1:0] live_mask;
  wire               drv_hiz;
  wire               drv_ones;
  wire               drv_zeros;

  // x18 parts have no upper two lanes: their masks read as high
  function [`LANES-1:0] lane_mask;
    input [`LANES-1:0] mask_n;
    input              narrow;
    begin
      lane_mask = narrow ? {2'b11, mask_n[1:0]} : mask_n;
    end
  endfunction

  // per-lane merge: unmasked lanes take new data, masked keep old
  function [`DATA_W-1:0] merge;
    input [`DATA_W-1:0] old_word;
    input [`DATA_W-1:0] new_word;
    input [`LANES-1:0]  mask_n;
    integer i;
    begin
      merge = old_word;
      for (i = 0; i < `LANES; i = i + 1) begin
        if (!mask_n[i])
          merge[i*`LANE_W +: `LANE_W] = new_word[i*`LANE_W +: `LANE_W];
      end
    end
  endfunction

  // x18 reads return zeros in the unused upper lanes
  function [`DATA_W-1:0] fold;
    input [`DATA_W-1:0] word;
    input               narrow;
    begin
      fold = narrow ? {{(2*`LANE_W){1'b0}}, word[2*`LANE_W-1:0]} : word;
    end
  endfunction

  assign mask1 = lane_mask(byte_lane_mask_n, x18_s2_reg);

  // write completes in the inverted slot; all-masked bursts are dropped
  assign wr_go = wr_pend_reg && !((&wr_mask0_reg) && (&mask1));

  // write address is only sampled now, in the inverted slot
  assign new0 = merge(mem_beat0[write_addr], wr_beat0_reg, wr_mask0_reg);
  assign new1 = merge(mem_beat1[write_addr], write_data, mask1);

  // same-slot match forwards the incoming burst instead of stale storage
  assign hit = wr_go && (write_addr == rd_addr_reg);
  assign rd0 = hit ? new0 : mem_beat0[rd_addr_reg];
  assign rd1 = hit ? new1 : mem_beat1[rd_addr_reg];

  // driver state seen by the calibration: only lanes that drive count
  assign live_mask = x18_s2_reg ? {{(2*`LANE_W){1'b0}}, {(2*`LANE_W){1'b1}}}
                                : {`DATA_W{1'b1}};
  assign drv_hiz   = !read_data_oe;
  assign drv_ones  = read_data_oe && ((read_data & live_mask) == live_mask);
  assign drv_zeros = read_data_oe && ((read_data & live_mask) == {`DATA_W{1'b0}});

  // strap and comparator pins are asynchronous to core_clk
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      x18_s1_reg <= 1'b0;
      x18_s2_reg <= 1'b0;
      pu_s1_reg  <= 1'b0;
      pu_s2_reg  <= 1'b0;
      pd_s1_reg  <= 1'b0;
      pd_s2_reg  <= 1'b0;
    end else if (clk_en) begin
      x18_s1_reg <= config_x18;
      x18_s2_reg <= x18_s1_reg;
      pu_s1_reg  <= pu_cmp_raise;
      pu_s2_reg  <= pu_s1_reg;
      pd_s1_reg  <= pd_cmp_raise;
      pd_s2_reg  <= pd_s1_reg;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      k_phase        <= 1'b0;
      wr_pend_reg    <= 1'b0;
      wr_beat0_reg   <= {`DATA_W{1'b0}};
      wr_mask0_reg   <= {`LANES{1'b1}};
      rd_pend_reg    <= 1'b0;
      rd_addr_reg    <= {`ADDR_W{1'b0}};
      beat1_pend_reg <= 1'b0;
      beat1_reg      <= {`DATA_W{1'b0}};
      read_data      <= {`DATA_W{1'b0}};
      read_data_oe   <= 1'b0;
    end else if (clk_en) begin
      k_phase <= !k_phase;
      if (!k_phase) begin
        // main edge: take both commands, read address and write beat one
        wr_pend_reg <= !write_n;
        rd_pend_reg <= !read_n;
        if (!write_n) begin
          wr_beat0_reg <= write_data;
          wr_mask0_reg <= lane_mask(byte_lane_mask_n, x18_s2_reg);
        end
        if (!read_n)
          rd_addr_reg <= read_addr;
        // second read beat goes out half a cycle after the first
        if (beat1_pend_reg) begin
          read_data    <= beat1_reg;
          read_data_oe <= 1'b1;
        end else begin
          read_data_oe <= 1'b0;
        end
        beat1_pend_reg <= 1'b0;
      end else begin
        // inverted edge: write address and beat two, burst stored here
        wr_pend_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
        if (rd_pend_reg) begin
          read_data      <= fold(rd0, x18_s2_reg);
          beat1_reg      <= fold(rd1, x18_s2_reg);
          read_data_oe   <= 1'b1;
          beat1_pend_reg <= 1'b1;
        end else begin
          read_data_oe   <= 1'b0;
        end
      end
    end
  end

  // storage write shares the inverted edge so a later read sees it
  always @(posedge core_clk) begin
    if (clk_en && k_phase && wr_go) begin
      mem_beat0[write_addr] <= new0;
      mem_beat1[write_addr] <= new1;
    end
  end

  impedance_cal #(
    .STARTUP_CYCLES (STARTUP_CYCLES),
    .CAL_PERIOD     (CAL_PERIOD)
  ) u_cal (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .k_tick     (!k_phase),
    .pu_raise   (pu_s2_reg),
    .pd_raise   (pd_s2_reg),
    .drv_hiz    (drv_hiz),
    .drv_ones   (drv_ones),
    .drv_zeros  (drv_zeros),
    .pu_code    (pu_code),
    .pd_code    (pd_code),
    .calibrated (calibrated)
  );

endmodule
`default_nettype wire

// ---- hw/impedance_cal.v ----
// output driver impedance calibration sequencer
`default_nettype none
`include "sram_port_consts.vh"

module impedance_cal #(
  parameter integer STARTUP_CYCLES = `STARTUP_CYCLES,
  parameter integer CAL_PERIOD     = `CAL_PERIOD
) (
  input  wire               core_clk,
  input  wire               rst_n,
  input  wire               clk_en,
  input  wire               k_tick,
  input  wire               pu_raise,
  input  wire               pd_raise,
  input  wire               drv_hiz,
  input  wire               drv_ones,
  input  wire               drv_zeros,
  output reg  [`CODE_W-1:0] pu_code,
  output reg  [`CODE_W-1:0] pd_code,
  output reg                calibrated
);

  localparam integer      STARTUP_M1   = STARTUP_CYCLES - 1;
  localparam integer      PERIOD_M1    = CAL_PERIOD - 1;
  localparam [`CNT_W-1:0] STARTUP_LAST = STARTUP_M1[`CNT_W-1:0];
  localparam [`CNT_W-1:0] PERIOD_LAST  = PERIOD_M1[`CNT_W-1:0];
  localparam [`CNT_W-1:0] CNT_ONE      = {{(`CNT_W-1){1'b0}}, 1'b1};

  reg [`CNT_W-1:0] start_cnt_reg;
  reg [`CNT_W-1:0] period_cnt_reg;
  reg              pu_pend_reg;
  reg              pd_pend_reg;
  reg              pu_dir_reg;
  reg              pd_dir_reg;
  wire             eval;

  // one binary step, saturating at both ends
  function [`CODE_W-1:0] step;
    input [`CODE_W-1:0] code;
    input               up;
    begin
      if (up)
        step = (code == `CODE_MAX) ? code : code + 6'h01;
      else
        step = (code == `CODE_MIN) ? code : code - 6'h01;
    end
  endfunction

  assign eval = k_tick && (period_cnt_reg == PERIOD_LAST);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_cnt_reg  <= {`CNT_W{1'b0}};
      period_cnt_reg <= {`CNT_W{1'b0}};
      calibrated     <= 1'b0;
      pu_pend_reg    <= 1'b0;
      pd_pend_reg    <= 1'b0;
      pu_dir_reg     <= 1'b0;
      pd_dir_reg     <= 1'b0;
      pu_code        <= `CODE_RST;
      pd_code        <= `CODE_RST;
    end else if (clk_en) begin
      // start-up count runs whether the port is selected or not
      if (k_tick && !calibrated) begin
        if (start_cnt_reg == STARTUP_LAST)
          calibrated <= 1'b1;
        else
          start_cnt_reg <= start_cnt_reg + CNT_ONE;
      end
      if (k_tick)
        period_cnt_reg <= eval ? {`CNT_W{1'b0}} : period_cnt_reg + CNT_ONE;
      // a pending step waits until the driver side it touches is idle
      if (pu_pend_reg && (drv_hiz || drv_zeros)) begin
        pu_code     <= step(pu_code, pu_dir_reg);
        pu_pend_reg <= 1'b0;
      end
      if (pd_pend_reg && (drv_hiz || drv_ones)) begin
        pd_code     <= step(pd_code, pd_dir_reg);
        pd_pend_reg <= 1'b0;
      end
      // a fresh evaluation wins over the clear of an applied step
      if (eval) begin
        pu_pend_reg <= 1'b1;
        pd_pend_reg <= 1'b1;
        pu_dir_reg  <= pu_raise;
        pd_dir_reg  <= pd_raise;
      end
    end
  end

endmodule
`default_nettype wire

// ---- include/sram_port_consts.vh ----
// constants for the ddr burst-of-two sram port logic
`ifndef SRAM_PORT_CONSTS_VH
`define SRAM_PORT_CONSTS_VH

// data path geometry
`define DATA_W          36
`define LANE_W          9
`define LANES           4
`define ADDR_W          18
`define WORDS           262144

// impedance code: binary-weighted steps
`define CODE_W          6
`define CODE_RST        6'h20
`define CODE_MAX        6'h3F
`define CODE_MIN        6'h00

// counters count main-clock cycles (one every second core_clk cycle)
`define CNT_W           20
`define STARTUP_CYCLES  32768
`define CAL_PERIOD      1024

`endif

// ---- sim/ddr_burst2_sram_port_logic_tb.sv ----
// self-checking bench for the ddr burst-of-two sram port logic
`default_nettype none
module ddr_burst2_sram_port_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic             core_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             clk_en = 1'b1;
  logic             config_x18 = 1'b0;
  logic             pu_cmp_raise = 1'b0;
  logic             pd_cmp_raise = 1'b0;
  wire logic        read_n, write_n, k_phase, read_data_oe, calibrated;
  wire logic [17:0] read_addr, write_addr;
  wire logic [35:0] write_data, read_data;
  wire logic [3:0]  byte_lane_mask_n;
  wire logic [5:0]  pu_code, pd_code;
  integer           mismatches = 0;
  integer           comparisons = 0;
  integer           seed = 32'h98BD;
  integer           cycles = 0;
  logic [17:0]      tab [4] = '{18'h00000, 18'h3FFFF, 18'h15A5A, 18'h2A5A5};
  logic [5:0]       pu_was, pd_was;
  logic             k_was;
  logic [63:0]      a, b;
  always #2 core_clk = ~core_clk;
  host_model host (.core_clk, .k_phase, .config_x18, .read_n, .read_addr, .write_n,
    .write_addr, .write_data, .byte_lane_mask_n);
  ddr_burst2_sram_port_logic #(.STARTUP_CYCLES(16), .CAL_PERIOD(4)) dut (.core_clk, .rst_n,
    .clk_en, .read_n, .read_addr, .write_n, .write_addr, .write_data,
    .byte_lane_mask_n, .config_x18, .pu_cmp_raise, .pd_cmp_raise, .k_phase, .read_data,
    .read_data_oe, .calibrated, .pu_code, .pd_code);
  task automatic check(input logic [35:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic idle(input integer n);
    repeat (n) host.op(1'b1, 1'b1, 18'h00000, 18'h00000, 36'h0, 36'h0, 8'hFF);
  endtask
  // random mix of reads, writes, deselects, partial and fully masked writes
  task automatic rnd_ops(input integer n);
    for (int i = 0; i < n; i++) begin
      a = {$random(seed), $random(seed)};
      b = {$random(seed), $random(seed)};
      pu_cmp_raise = a[62];
      pd_cmp_raise = a[63];
      host.op(a[40], a[41], tab[a[43:42]], tab[a[45:44]], a[35:0], b[35:0],
        a[47:46] == 2'b00 ? 8'hFF : b[63:56]);
    end
  endtask
  always @(negedge core_clk) begin
    if (read_data_oe === 1'b1) begin
      if (host.exp_q.size() == 0) begin
        comparisons++;
        mismatches++;
        $display("Error at %0t: got %h expected %h", $time, read_data, 36'h000000000);
      end
      else check(read_data, host.exp_q.pop_front());
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      a = {$random(seed), $random(seed)};
      host.op(1'b0, 1'b0, tab[i], tab[i], a[35:0], a[63:28], 8'h00);
    end
    rnd_ops(60);
    for (int d = 1; d >= 0; d--) begin
      pu_cmp_raise = d[0];
      pd_cmp_raise = d[0];
      pu_was = pu_code;
      pd_was = pd_code;
      idle(40);
      check({35'h0, d ? (pu_code > pu_was && pd_code > pd_was) :
        (pu_code < pu_was && pd_code < pd_was)}, 36'h1);
    end
    check({35'h0, calibrated}, 36'h1);
    // enable low must hold every flop; an odd cycle count catches a running phase
    pu_was = pu_code;
    pd_was = pd_code;
    k_was = k_phase;
    clk_en = 1'b0;
    repeat (21) @(negedge core_clk);
    check({23'h0, k_phase, pu_code, pd_code}, {23'h0, k_was, pu_was, pd_was});
    clk_en = 1'b1;
    // mid-run reset restores start-up values and restarts the start-up count
    rst_n = 1'b0;
    @(negedge core_clk);
    check({21'h0, k_phase, calibrated, read_data_oe, pu_code, pd_code},
      {21'h0, 3'b000, 6'h20, 6'h20});
    rst_n = 1'b1;
    config_x18 = 1'b1;
    idle(3);
    rnd_ops(40);
    idle(3);
    check(36'(host.exp_q.size()), 36'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- sim/host_model.sv ----
// host controller model: issues paired commands and notes expected read beats
`default_nettype none
module host_model (
  input  wire logic        core_clk,
  input  wire logic        k_phase,
  input  wire logic        config_x18,
  output logic             read_n,
  output logic [17:0]      read_addr,
  output logic             write_n,
  output logic [17:0]      write_addr,
  output logic [35:0]      write_data,
  output logic [3:0]       byte_lane_mask_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] mem0 [logic [17:0]];
  logic [35:0] mem1 [logic [17:0]];
  logic [35:0] exp_q [$];
  initial begin
    read_n = 1'b1;
    write_n = 1'b1;
    read_addr = 18'h00000;
    write_addr = 18'h00000;
    write_data = 36'h000000000;
    byte_lane_mask_n = 4'hF;
  end
  function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] m);
    for (int i = 0; i < 4; i++) if (!m[i]) o[9*i +: 9] = n[9*i +: 9];
    return o;
  endfunction
  // m holds beat two masks above beat one masks
  task automatic op(input logic rn, wn, input logic [17:0] ra, wa,
                    input logic [35:0] first_write_beat, second_write_beat,
                    input logic [7:0] m);
    logic [3:0]  f;
    logic [35:0] live;
    f = config_x18 ? 4'hC : 4'h0;
    live = config_x18 ? 36'h00003FFFF : 36'hFFFFFFFFF;
    do @(negedge core_clk); while (k_phase);
    read_n = rn;
    read_addr = ra;
    write_n = wn;
    write_data = first_write_beat;
    byte_lane_mask_n = m[3:0];
    @(negedge core_clk);
    read_n = 1'b1;
    read_addr = ~ra;
    write_addr = wa;
    write_data = second_write_beat;
    byte_lane_mask_n = m[7:4];
    if (!wn) begin
      mem0[wa] = merge(mem0[wa], first_write_beat, m[3:0] | f);
      mem1[wa] = merge(mem1[wa], second_write_beat, m[7:4] | f);
    end
    // updating before the lookup gives the same-cycle pass-through result
    if (!rn) begin
      exp_q.push_back(mem0[ra] & live);
      exp_q.push_back(mem1[ra] & live);
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/sram_port_assertions.sv ----
// checker of read timing, impedance steps and start-up of the sram port logic
`default_nettype none
module sram_port_checker #(
  parameter integer STARTUP_CYCLES = 16
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic        read_n,
  input wire logic        config_x18,
  input wire logic        k_phase,
  input wire logic [35:0] read_data,
  input wire logic        read_data_oe,
  input wire logic        calibrated,
  input wire logic [5:0]  pu_code,
  input wire logic [5:0]  pd_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] cyc_reg;
  // counts enabled edges only, as the start-up counter does
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cyc_reg <= 20'h00000;
    else if (clk_en && cyc_reg != 20'hFFFFF) cyc_reg <= cyc_reg + 20'h00001;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_READ_OE: assert property (!k_phase && !read_n && clk_en |-> ##2 read_data_oe [*2])
    else $error("read beats not driven");
  AST_DESELECT: assert property (!k_phase && read_n && clk_en |-> ##2 (!read_data_oe) [*2])
    else $error("deselected read port drives");
  AST_OE_CAUSE: assert property ($rose(read_data_oe) |-> !$past(k_phase, 2) && !$past(read_n, 2))
    else $error("read beats without a request");
  AST_PU_STEP: assert property ($changed(pu_code) |->
    pu_code == $past(pu_code) + 6'h01 || pu_code == $past(pu_code) - 6'h01)
    else $error("pull-up code jumped");
  AST_PD_STEP: assert property ($changed(pd_code) |->
    pd_code == $past(pd_code) + 6'h01 || pd_code == $past(pd_code) - 6'h01)
    else $error("pull-down code jumped");
  AST_PU_WHEN: assert property ($changed(pu_code) |->
    !$past(read_data_oe) || $past(read_data) == 36'h000000000)
    else $error("pull-up code moved while driving ones");
  AST_PD_WHEN: assert property ($changed(pd_code) |->
    !$past(read_data_oe) || &($past(read_data) | {{18{$past(config_x18)}}, 18'h00000}))
    else $error("pull-down code moved while driving zeros");
  AST_CAL_DONE: assert property (cyc_reg == 2 * STARTUP_CYCLES + 6 |-> calibrated)
    else $error("start-up period overran");
  AST_CAL_EARLY: assert property (cyc_reg < 2 * STARTUP_CYCLES - 2 |-> !calibrated)
    else $error("start-up period cut short");
  AST_X18_UPPER: assert property (read_data_oe && config_x18 && $past(config_x18, 6) |->
    read_data[35:18] == 18'h00000)
    else $error("narrow mode drives upper lanes");
endmodule
bind ddr_burst2_sram_port_logic sram_port_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk (
  .core_clk, .rst_n, .clk_en, .read_n, .config_x18, .k_phase, .read_data, .read_data_oe,
  .calibrated, .pu_code, .pd_code);
`default_nettype wire
